/* File: src/rsc_pkg.sv */
/*
 Shared constants for the reset source controller: register offsets, field
 positions, reset values, option-byte layout and timing counts.
 Assumes a 125 MHz system clock and an Avalon-MM slave with 32-bit words.
*/
// Notes on behaviour
// - A low external reset pin starts and holds a hardware reset.
// - A power-rise indication from the supply monitor starts a power-on reset.
// - Supply-drop indications 0, 1, 2 start voltage monitor 0, 1, 2 resets.
// - A main oscillator stop report starts an oscillation-stop reset.
// - Writing 1 to bit 3 of mode register zero starts a software reset.
// - Mode register zero writes are ignored unless the unlock bit is set.
// - Mode field survives software, watchdog, osc-stop, monitor 1 and 2 resets.
// - Mode register loads 00h with strap low, 03h with strap high.
// - Each reset but power-on and monitor 0 sets its own cause flag, clears others; pin reset keeps osc-stop.
// - Power-on and monitor 0 clear all flags and cold/warm; others keep cold/warm.
// - Cold/warm flag becomes 1 only by a software write of 1.
// - Osc-stop flag cleared by writing 0; writing 1 has no effect.
// - After a pin reset the cause register reads XX00 001Xb.
// - Option byte is read-only and reads FFh when erased.
// - Option bit 0 clear autostarts watchdog; bit 7 clear enables count protection.
// - Flash blocked in parallel mode only when cancel bit 1 and protect bit 0.
// - Option bit 6 clear enables monitor 0 reset; must be clear for power-on.
// - Values loaded at reset depend on the reset type that occurred.
// - In reset, single-chip pins are inputs; boot mode uses chip enable and prog input.
// - Microprocessor reset drives strobes high, latch strobe low, pulls P4_5..7, hold ack follows.
// - Power-on or monitor 0 release waits 32 slow oscillator cycles.
// - After any release the CPU clock is slow oscillator divided by 8.
// - Osc-stop reset persists until a pin, power-on or monitor 0 reset.
// - Watchdog underflow resets only while the watchdog reset select bit is set.
package rsc_pkg;
    localparam logic [15:0] RSC_OFF_PM0 = 16'h0004;
    localparam logic [15:0] RSC_OFF_FLAGS = 16'h0018;
    localparam logic [15:0] RSC_OFF_PM1 = 16'h0008;
    localparam logic [15:0] RSC_OFF_UNLOCK = 16'h000c;
    localparam logic [15:0] RSC_OFF_OPTION = 16'h0010;
    localparam logic [15:0] RSC_OFF_STATUS = 16'h0014;

    localparam int RSC_PM0_MODE_LO = 0;
    localparam int RSC_PM0_MODE_HI = 1;
    localparam int RSC_PM0_SOFT = 3;
    localparam int RSC_PM1_DOG_SEL = 2;

    localparam int RSC_F_CWR = 0;
    localparam int RSC_F_PIN = 1;
    localparam int RSC_F_SW = 2;
    localparam int RSC_F_DOG = 3;
    localparam int RSC_F_VM1 = 4;
    localparam int RSC_F_VM2 = 5;
    localparam int RSC_F_OSC = 6;

    localparam int RSC_O_AUTOSTART_N = 0;
    localparam int RSC_O_CP_CANCEL = 2;
    localparam int RSC_O_CP_BIT = 3;
    localparam int RSC_O_VSEL = 5;
    localparam int RSC_O_VM0_START_N = 6;
    localparam int RSC_O_CSP_N = 7;

    localparam logic [7:0] RSC_PM0_RST_LOW = 8'h00;
    localparam logic [7:0] RSC_PM0_RST_HIGH = 8'h03;
    localparam logic [7:0] RSC_OPTION_ERASED = 8'hff;
    localparam logic [7:0] RSC_BYTE_ZERO = 8'h00;

    localparam int RSC_SLOW_OSC_COUNT = 32;
    localparam int RSC_CPU_DIV = 8;
    // Slow on-chip oscillator nominal period, ns; 125 MHz clock is 8 ns
    localparam int RSC_SLOW_OSC_PERIOD_NS = 8000;
    localparam int RSC_CLK_PERIOD_NS = 8;
    localparam int RSC_SLOW_OSC_CYCLES = (RSC_SLOW_OSC_PERIOD_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        RSC_ST_RUN = 4'b0001,
        RSC_ST_HOLD = 4'b0010,
        RSC_ST_COUNT = 4'b0100,
        RSC_ST_STUCK = 4'b1000
    } rsc_state_e;
endpackage : rsc_pkg

/* File: src/rsc_reset_source_controller.sv */
/*
 Reset source controller: gathers the eight reset sources, sequences the
 chip reset, records the cause and holds mode register zero.
 Assumes the voltage, oscillator and watchdog monitors are asynchronous
 level sources and that software uses Avalon-MM with waitrequest.
*/
`timescale 1ns/1ns
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int SLOW_OSC_CYCLES = RSC_SLOW_OSC_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ext_reset_n,
    input wire logic i_power_rise,
    input wire logic i_vmon0_drop,
    input wire logic i_vmon1_drop,
    input wire logic i_vmon2_drop,
    input wire logic i_osc_stopped,
    input wire logic i_dog_underflow,
    input wire logic i_mode_strap_pin,
    input wire logic i_boot_sel_pin,
    input wire logic i_hold_req,
    input wire logic [7:0] i_option_byte_one,
    input wire logic [15:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_chip_reset_n,
    output logic o_cpu_clk_en,
    output logic o_dog_autostart,
    output logic o_count_src_protect,
    output logic o_code_protect,
    output logic o_vmon0_enable,
    output logic o_chip_select_zero,
    output logic o_write_strobe_n,
    output logic o_read_strobe_n,
    output logic o_addr_latch,
    output logic o_hold_ack_out,
    output logic o_port_pullup_en,
    output logic o_chip_enable_sel,
    output logic o_prog_mode_input_sel
);
    localparam int CW = $clog2(SLOW_OSC_CYCLES * RSC_SLOW_OSC_COUNT + 1);
    localparam logic [CW-1:0] COUNT_TOP = CW'(SLOW_OSC_CYCLES * RSC_SLOW_OSC_COUNT - 1);

    // Two-flop synchronisers for every asynchronous source
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    always_ff @(posedge i_ref_clk) begin
        sync1_q <= {i_hold_req, i_boot_sel_pin, i_mode_strap_pin, i_dog_underflow, i_osc_stopped,
                    i_vmon2_drop, i_vmon1_drop, i_vmon0_drop, i_power_rise};
        sync2_q <= sync1_q;
    end
    // Pin synchroniser, same depth as the others so concurrent sources rank fairly
    logic sync1_ext_q;
    logic sync2_ext_q;
    always_ff @(posedge i_ref_clk) begin
        sync1_ext_q <= i_ext_reset_n;
        sync2_ext_q <= sync1_ext_q;
    end

    wire s_por = sync2_q[0];
    wire s_vm0 = sync2_q[1];
    wire s_vm1 = sync2_q[2];
    wire s_vm2 = sync2_q[3];
    wire s_osc = sync2_q[4];
    wire s_dog = sync2_q[5];
    wire s_strap = sync2_q[6];
    wire s_boot = sync2_q[7];
    wire s_hold = sync2_q[8];

    logic [7:0] pm0_q;
    logic [7:0] pm1_q;
    logic unlock_q;
    logic [6:0] flags_q;
    rsc_state_e state_q;
    logic [CW-1:0] cnt_q;

    // Bus decode; one wait cycle, answer at the second edge
    logic ack_q;
    wire req = (i_avs_read | i_avs_write) & ~ack_q;
    wire wr_ok = i_avs_write & ack_q & i_avs_byteenable[0];
    wire wr_pm0 = wr_ok & (i_avs_address == RSC_OFF_PM0) & unlock_q;
    wire wr_pm1 = wr_ok & (i_avs_address == RSC_OFF_PM1) & unlock_q;
    wire wr_unl = wr_ok & (i_avs_address == RSC_OFF_UNLOCK);
    wire wr_flg = wr_ok & (i_avs_address == RSC_OFF_FLAGS);

    // Reset source events, ranked: power-on/monitor 0, pin, then others
    wire ev_cold = s_por | (s_vm0 & ~i_option_byte_one[RSC_O_VM0_START_N]);
    wire ev_pin = ~sync2_ext_q;
    wire ev_vm1 = s_vm1;
    wire ev_vm2 = s_vm2;
    wire ev_osc = s_osc;
    wire ev_dog = s_dog & pm1_q[RSC_PM1_DOG_SEL];
    wire ev_sw = wr_pm0 & i_avs_writedata[RSC_PM0_SOFT];
    wire ev_warm = ev_vm1 | ev_vm2 | ev_osc | ev_dog | ev_sw;
    wire ev_any = ev_cold | ev_pin | ev_warm;
    logic first_q;

    // Reset sequencer
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_q <= RSC_ST_COUNT;
            cnt_q <= '0;
        end else begin
            case (state_q)
                RSC_ST_RUN: begin
                    if (ev_any) begin
                        state_q <= (ev_osc & ~ev_cold & ~ev_pin) ? RSC_ST_STUCK : RSC_ST_HOLD;
                    end
                end
                RSC_ST_HOLD: begin
                    cnt_q <= '0;
                    if (ev_osc & ~ev_cold & ~ev_pin) begin
                        state_q <= RSC_ST_STUCK;
                    end else if (!(ev_cold | ev_pin | ev_vm1 | ev_vm2 | ev_dog)) begin
                        state_q <= RSC_ST_COUNT; // held while pin stays low
                    end
                end
                RSC_ST_COUNT: begin
                    if (ev_any) begin
                        state_q <= RSC_ST_HOLD;
                    end else if (cnt_q == COUNT_TOP) begin
                        state_q <= RSC_ST_RUN; // 32 slow oscillator cycles
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                RSC_ST_STUCK: begin
                    if (ev_cold | ev_pin) begin
                        state_q <= RSC_ST_HOLD; // only pin, power-on or monitor 0 cancel
                    end
                end
                default: state_q <= RSC_ST_HOLD;
            endcase
        end
    end

    // First-cycle flag: set while i_rst_n is low, cleared at the first edge after release
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // Cause flags; hardware events win over a software write
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            flags_q <= 7'h00;
        end else if (ev_cold) begin
            flags_q <= 7'h00;
        end else if (ev_pin) begin
            flags_q <= (flags_q & 7'h41) | 7'h02; // keep osc-stop and cold/warm
        end else if (ev_warm) begin
            flags_q[RSC_F_PIN] <= 1'b0;
            flags_q[RSC_F_SW] <= ev_sw & ~ev_osc & ~ev_dog & ~ev_vm1 & ~ev_vm2;
            flags_q[RSC_F_DOG] <= ev_dog & ~ev_osc & ~ev_vm1 & ~ev_vm2;
            flags_q[RSC_F_VM1] <= ev_vm1 & ~ev_osc;
            flags_q[RSC_F_VM2] <= ev_vm2 & ~ev_vm1 & ~ev_osc;
            flags_q[RSC_F_OSC] <= ev_osc;
        end else if (wr_flg) begin
            if (i_avs_writedata[RSC_F_CWR]) begin
                flags_q[RSC_F_CWR] <= 1'b1;
            end
            if (!i_avs_writedata[RSC_F_OSC]) begin
                flags_q[RSC_F_OSC] <= 1'b0;
            end
        end
    end

    // Mode register zero: mode field kept over warm resets
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pm0_q <= RSC_PM0_RST_LOW;
        end else if (first_q | ev_cold | ev_pin) begin
            pm0_q <= s_strap ? RSC_PM0_RST_HIGH : RSC_PM0_RST_LOW;
        end else if (ev_warm) begin
            pm0_q <= pm0_q & RSC_PM0_RST_HIGH;
        end else if (wr_pm0) begin
            pm0_q <= i_avs_writedata[7:0] & ~(8'h01 << RSC_PM0_SOFT);
        end
    end

    // Mode register one and unlock bit
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || ev_any) begin
            pm1_q <= RSC_BYTE_ZERO;
            unlock_q <= 1'b0;
        end else begin
            if (wr_pm1) begin
                pm1_q <= i_avs_writedata[7:0];
            end
            if (wr_unl) begin
                unlock_q <= i_avs_writedata[0];
            end
        end
    end

    // Avalon answer and read mux
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            o_avs_waitrequest <= ~req;
            if (req && i_avs_read) begin
                case (i_avs_address)
                    RSC_OFF_PM0: o_avs_readdata <= {24'h000000, pm0_q};
                    RSC_OFF_PM1: o_avs_readdata <= {24'h000000, pm1_q};
                    RSC_OFF_UNLOCK: o_avs_readdata <= {31'h00000000, unlock_q};
                    RSC_OFF_FLAGS: o_avs_readdata <= {25'h0000000, flags_q};
                    RSC_OFF_OPTION: o_avs_readdata <= {24'h000000, i_option_byte_one};
                    RSC_OFF_STATUS: o_avs_readdata <= {28'h0000000, state_q};
                    default: o_avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // CPU clock enable: slow oscillator tick divided by 8
    logic [$clog2(SLOW_OSC_CYCLES * RSC_CPU_DIV)-1:0] div_q;
    localparam int DW = $clog2(SLOW_OSC_CYCLES * RSC_CPU_DIV);
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || state_q != RSC_ST_RUN) begin
            div_q <= '0;
            o_cpu_clk_en <= 1'b0;
        end else begin
            o_cpu_clk_en <= (div_q == DW'(SLOW_OSC_CYCLES * RSC_CPU_DIV - 1));
            div_q <= (div_q == DW'(SLOW_OSC_CYCLES * RSC_CPU_DIV - 1)) ? '0 : div_q + 1'b1;
        end
    end

    // Chip reset and option-byte decode
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_chip_reset_n <= 1'b0;
            o_dog_autostart <= 1'b0;
            o_count_src_protect <= 1'b0;
            o_code_protect <= 1'b0;
            o_vmon0_enable <= 1'b0;
        end else begin
            o_chip_reset_n <= (state_q == RSC_ST_RUN) & ~ev_any;
            o_dog_autostart <= ~i_option_byte_one[RSC_O_AUTOSTART_N];
            o_count_src_protect <= ~i_option_byte_one[RSC_O_CSP_N];
            o_code_protect <= i_option_byte_one[RSC_O_CP_CANCEL] & ~i_option_byte_one[RSC_O_CP_BIT];
            o_vmon0_enable <= ~i_option_byte_one[RSC_O_VM0_START_N];
        end
    end

    // Pin states while reset is held, per strap mode
    wire in_rst = state_q != RSC_ST_RUN;
    wire upmode = s_strap & s_boot;
    wire bootm = s_strap & ~s_boot;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_chip_select_zero <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_addr_latch <= 1'b0;
            o_hold_ack_out <= 1'b0;
            o_port_pullup_en <= 1'b0;
            o_chip_enable_sel <= 1'b0;
            o_prog_mode_input_sel <= 1'b0;
        end else begin
            o_chip_select_zero <= 1'b1; // strobes idle high
            o_write_strobe_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_addr_latch <= 1'b0;
            o_hold_ack_out <= upmode & s_hold;
            o_port_pullup_en <= in_rst & upmode;
            o_chip_enable_sel <= in_rst & bootm;
            o_prog_mode_input_sel <= in_rst & bootm;
        end
    end
endmodule : rsc_reset_source_controller

/* File: bench/rsc_monitor.sv */
/*
 Port checker for the reset source controller, bound into its top module.
 Assumes SLOW_OSC_CYCLES is 1, so the CPU clock enable repeats every 8 clocks.
*/
`timescale 1ns/1ns
module rsc_monitor
    import rsc_pkg::*;
#(
    parameter int SLOW_OSC_CYCLES = RSC_SLOW_OSC_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ext_reset_n,
    input wire logic i_power_rise,
    input wire logic i_vmon1_drop,
    input wire logic i_vmon2_drop,
    input wire logic i_osc_stopped,
    input wire logic [7:0] i_option_byte_one,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic o_chip_reset_n,
    input wire logic o_cpu_clk_en,
    input wire logic o_dog_autostart,
    input wire logic o_count_src_protect,
    input wire logic o_code_protect,
    input wire logic o_vmon0_enable,
    input wire logic o_chip_select_zero,
    input wire logic o_write_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic o_addr_latch
);
    int unsigned low_q;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // Length of the current chip reset; a long count cannot be a repetition
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || o_chip_reset_n) low_q <= 0;
        else low_q <= low_q + 1;
    end

    property p_pin_hold; !i_ext_reset_n [*5] |-> !o_chip_reset_n; endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin low but chip runs");
    property p_por; i_power_rise [*5] |-> !o_chip_reset_n; endproperty
    a_por: assert property (p_por) else $error("power rise without reset");
    property p_vmon; (i_vmon1_drop || i_vmon2_drop) [*5] |-> !o_chip_reset_n; endproperty
    a_vmon: assert property (p_vmon) else $error("supply drop without reset");
    property p_osc; i_osc_stopped [*5] |-> !o_chip_reset_n; endproperty
    a_osc: assert property (p_osc) else $error("osc stop without reset");
    property p_release; $rose(o_chip_reset_n) |-> low_q >= SLOW_OSC_CYCLES * RSC_SLOW_OSC_COUNT - 1; endproperty
    a_release: assert property (p_release) else $error("reset released early");
    property p_clk_gap; o_cpu_clk_en && o_chip_reset_n |=> !o_cpu_clk_en [*7] ##1 (o_cpu_clk_en || !o_chip_reset_n);
    endproperty
    a_clk_gap: assert property (p_clk_gap) else $error("cpu clock enable spacing wrong");
    property p_answer; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_no_req; !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    a_no_req: assert property (p_no_req) else $error("bus answer without request");
    property p_strobes; o_chip_select_zero && o_write_strobe_n && o_read_strobe_n && !o_addr_latch; endproperty
    a_strobes: assert property (p_strobes) else $error("bus strobe levels wrong");
    property p_option;
        $stable(i_option_byte_one) [*2] |-> o_dog_autostart == !i_option_byte_one[0]
            && o_count_src_protect == !i_option_byte_one[7] && o_vmon0_enable == !i_option_byte_one[6]
            && o_code_protect == (i_option_byte_one[2] && !i_option_byte_one[3]);
    endproperty
    a_option: assert property (p_option) else $error("option outputs wrong");

    // Main scenarios reached
    c_release: cover property ($rose(o_chip_reset_n));
    c_stuck: cover property ($fell(i_osc_stopped) ##8 !o_chip_reset_n);
    c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule : rsc_monitor

bind rsc_reset_source_controller rsc_monitor #(.SLOW_OSC_CYCLES(SLOW_OSC_CYCLES)) rsc_monitor_inst (
    .i_ref_clk, .i_rst_n, .i_ext_reset_n, .i_power_rise, .i_vmon1_drop, .i_vmon2_drop, .i_osc_stopped,
    .i_option_byte_one, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_chip_reset_n, .o_cpu_clk_en,
    .o_dog_autostart, .o_count_src_protect, .o_code_protect, .o_vmon0_enable, .o_chip_select_zero,
    .o_write_strobe_n, .o_read_strobe_n, .o_addr_latch);

/* File: bench/rsc_src_model.sv */
/*
 Far-side model: reset pin, supply, oscillator and watchdog monitors, option byte.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ns
module rsc_src_model (
    input wire logic i_ref_clk,
    output logic [6:0] o_src,
    output logic [7:0] o_option
);
    // Bit 0 pin, 1 power rise, 2..4 monitors 0..2, 5 osc stop, 6 watchdog
    logic [6:0] src_q = 7'h00;
    logic [7:0] opt_q = 8'h04; // Autostart on with count protect, 2.85 V, monitor 0 on
    assign o_src = src_q;
    assign o_option = opt_q;

    // Sources are levels held for n clocks; the pin is inverted by the bench
    task automatic fire(input logic [6:0] m, input int n);
        src_q <= m;
        repeat (n) @(posedge i_ref_clk);
        src_q <= 7'h00;
    endtask : fire

    // Option byte is static in use; changed only between checks
    task automatic set_opt(input logic [7:0] v);
        opt_q <= v;
    endtask : set_opt
endmodule : rsc_src_model

/* File: bench/rsc_reset_source_controller_tb.sv */
/*
 Testbench for the reset source controller: Avalon-MM tasks and reset scenarios.
 Assumes SLOW_OSC_CYCLES of 1 and the source model in rsc_src_model.
*/
`timescale 1ns/1ns
module rsc_reset_source_controller_tb;
    import rsc_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic strap = 1'b0;
    logic boot = 1'b0;
    logic hold = 1'b0;
    logic [31:0] q;
    logic [31:0] rdat;
    logic [6:0] src;
    logic [7:0] opt;
    logic wq, rst_on, cken, dg, cs, cp, v0, ha, pu, ce, pm;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int wsrc[3] = '{6, 3, 4};
    int wflg[3] = '{RSC_F_DOG, RSC_F_VM1, RSC_F_VM2};
    logic [7:0] ov[4] = '{8'h7e, 8'h04, 8'h08, 8'hff};

    rsc_src_model rsc_src_model_inst (.i_ref_clk, .o_src(src), .o_option(opt));
    rsc_reset_source_controller #(.SLOW_OSC_CYCLES(1)) rsc_reset_source_controller_inst (
        .i_ref_clk, .i_rst_n, .i_ext_reset_n(!src[0]), .i_power_rise(src[1]), .i_vmon0_drop(src[2]),
        .i_vmon1_drop(src[3]), .i_vmon2_drop(src[4]), .i_osc_stopped(src[5]), .i_dog_underflow(src[6]),
        .i_mode_strap_pin(strap), .i_boot_sel_pin(boot), .i_hold_req(hold), .i_option_byte_one(opt),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .o_chip_reset_n(rst_on), .o_cpu_clk_en(cken),
        .o_dog_autostart(dg), .o_count_src_protect(cs), .o_code_protect(cp), .o_vmon0_enable(v0),
        .o_chip_select_zero(), .o_write_strobe_n(), .o_read_strobe_n(), .o_addr_latch(), .o_hold_ack_out(ha),
        .o_port_pullup_en(pu), .o_chip_enable_sel(ce), .o_prog_mode_input_sel(pm));

    // 125 MHz clock
    initial begin
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // Hang guard, well above the eight hundred or so cycles the run needs
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One Avalon-MM transfer; held until waitrequest is sampled low, hang guard ends a stall
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        @(posedge i_ref_clk);
        while (wq !== 1'b0) begin
            @(posedge i_ref_clk);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask : bus

    task automatic rdc(input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rdc

    // Bounded wait for the chip to leave reset
    task automatic run_wait();
        int n;
        n = 0;
        while (rst_on !== 1'b1 && n < 400) begin
            @(posedge i_ref_clk);
            n++;
        end
        if (n == 400) n_fail++;
    endtask : run_wait

    // Raise sources, see the chip held, then read the recorded cause
    task automatic hit(input logic [6:0] m, input logic [31:0] f);
        rsc_src_model_inst.fire(m, 8);
        chk({31'h0, rst_on}, 32'h0);
        run_wait();
        rdc(RSC_OFF_FLAGS, f);
    endtask : hit

    // Main sequence
    initial begin
        int k;
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        run_wait();
        rdc(RSC_OFF_PM0, 32'h0);
        rdc(RSC_OFF_FLAGS, 32'h0);
        bus(1'b1, RSC_OFF_OPTION, 32'h0);
        rdc(RSC_OFF_OPTION, 32'h04);
        rdc(16'h0040, 32'h0);
        bus(1'b1, RSC_OFF_PM0, 32'h3);
        rdc(RSC_OFF_PM0, 32'h0);
        bus(1'b1, RSC_OFF_UNLOCK, 32'h1);
        bus(1'b1, RSC_OFF_PM0, 32'h3);
        rdc(RSC_OFF_PM0, 32'h3);
        bus(1'b1, RSC_OFF_FLAGS, 32'h41);
        rdc(RSC_OFF_FLAGS, 32'h1);
        $display("test registers done");
        bus(1'b1, RSC_OFF_PM0, 32'h0b);
        repeat (8) @(posedge i_ref_clk);
        chk({31'h0, rst_on}, 32'h0);
        run_wait();
        rdc(RSC_OFF_FLAGS, 32'h5);
        rdc(RSC_OFF_PM0, 32'h3);
        bus(1'b1, RSC_OFF_UNLOCK, 32'h1);
        bus(1'b1, RSC_OFF_PM1, 32'h4);
        for (int i = 0; i < 3; i++) begin
            hit(7'h1 << wsrc[i], (32'h1 << wflg[i]) | 32'h1);
            rdc(RSC_OFF_PM0, 32'h3);
        end
        bus(1'b1, RSC_OFF_UNLOCK, 32'h1);
        bus(1'b1, RSC_OFF_PM1, 32'h0);
        rsc_src_model_inst.fire(7'h40, 8);
        repeat (4) @(posedge i_ref_clk);
        chk({31'h0, rst_on}, 32'h1);
        $display("test warm resets done");
        rsc_src_model_inst.fire(7'h20, 8);
        repeat (100) @(posedge i_ref_clk);
        chk({31'h0, rst_on}, 32'h0);
        rdc(RSC_OFF_STATUS, 32'h8);
        rdc(RSC_OFF_FLAGS, 32'h41);
        hit(7'h01, 32'h43);
        rdc(RSC_OFF_PM0, 32'h0);
        bus(1'b1, RSC_OFF_FLAGS, 32'h41);
        rdc(RSC_OFF_FLAGS, 32'h43);
        bus(1'b1, RSC_OFF_FLAGS, 32'h01);
        rdc(RSC_OFF_FLAGS, 32'h03);
        hit(7'h09, 32'h03);
        hit(7'h03, 32'h00);
        $display("test osc stop and precedence done");
        strap <= 1'b1;
        boot <= 1'b1;
        hold <= 1'b1;
        rsc_src_model_inst.fire(7'h02, 8);
        chk({29'h0, pu, ce, ha}, 32'h5);
        hold <= 1'b0;
        run_wait();
        rdc(RSC_OFF_PM0, 32'h3);
        boot <= 1'b0;
        rsc_src_model_inst.fire(7'h04, 8);
        chk({29'h0, pu, ce, pm}, 32'h3);
        run_wait();
        rdc(RSC_OFF_FLAGS, 32'h0);
        $display("test cold resets and pins done");
        for (int i = 0; i < 4; i++) begin
            rsc_src_model_inst.set_opt(ov[i]);
            repeat (3) @(posedge i_ref_clk);
            chk({28'h0, dg, cs, cp, v0}, {28'h0, !ov[i][0], !ov[i][7], ov[i][2] & !ov[i][3], !ov[i][6]});
        end
        rdc(RSC_OFF_OPTION, 32'hff);
        rsc_src_model_inst.fire(7'h04, 8);
        repeat (4) @(posedge i_ref_clk);
        chk({31'h0, rst_on}, 32'h1);
        k = 0;
        repeat (80) begin
            @(posedge i_ref_clk);
            if (cken === 1'b1) k++;
        end
        chk(k, 32'd10);
        $display("test option and clock done");
        summarize();
    end
endmodule : rsc_reset_source_controller_tb
